/* css_selector.sv */
// Functional notes
// - two settings choose frequency and run sources
// - serial selector: links; override: field bus
// - frequency: 0,2,6 local; 1,3,7 std; else ext
// - run: 0,1,4 local; 2,3,5 std; else ext
// - override 1 freq, 2 run, 3 both
// - forced source ignores serial selector
// - local frequency: setting or multistep
// - local run: keypad or input terminals
// - standard link shares keypad port
// - assigned enable terminal must be shorted
// - open enable terminal voids settings
// - void settings mean local sources
// - remote reads status, writes commands
//
// Command source selector with APB register access.
// Assumes command payloads arrive on synchronous ports, one per source.
//
// Implementation choices: the address map and register access over APB.
`timescale 1ns/1ps
`include "css_consts.svh"
module css_selector
  import css_pkg::*;
#(
  parameter int FREQ_W = 16
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Link enable terminal
  input wire logic link_enable_assigned,
  input wire logic link_enable_input_n,
  // Local frequency sources
  input wire logic [FREQ_W-1:0] local_frequency_setting,
  input wire logic [FREQ_W-1:0] local_frequency_setting_alt,
  input wire logic [FREQ_W-1:0] multistep_freq,
  input wire logic multistep_active,
  // Local run sources
  input wire logic [1:0] keypad_run,
  input wire logic [1:0] terminal_run,
  // Remote sources (standard shares keypad port)
  input wire logic [FREQ_W-1:0] std_freq,
  input wire logic [1:0] std_run,
  input wire logic [FREQ_W-1:0] ext_freq,
  input wire logic [1:0] ext_run,
  input wire logic [FREQ_W-1:0] fbus_freq,
  input wire logic [1:0] fbus_run,
  // Selected commands
  output logic [FREQ_W-1:0] freq_cmd,
  output logic [1:0] run_cmd,
  output logic [1:0] freq_src_out,
  output logic [1:0] run_src_out
);

  ////////////////////////////////////////////////////////////////////////
  // Decode helpers

  // Byte address match for one register
  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    hit = (a == o);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Registers

  logic [`CSS_SEL_W-1:0] serial_link_source_select_reg;
  logic [`CSS_OVR_W-1:0] fieldbus_source_override_reg;
  logic [1:0] local_cfg_reg; // [0] alt freq setting, [1] keypad run
  logic reject_reg;
  logic wr_en;
  logic rd_en;
  logic mapped;
  logic effective;
  css_src_t frq_src;
  css_src_t run_src;

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign mapped = hit(paddr, `CSS_SEL_OFS) || hit(paddr, `CSS_OVR_OFS) ||
    hit(paddr, `CSS_LOC_OFS) || hit(paddr, `CSS_STAT_OFS);

  assign effective = !link_enable_assigned || !link_enable_input_n;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_link_source_select_reg <= `CSS_SEL_RST;
    end else if (wr_en && hit(paddr, `CSS_SEL_OFS) &&
                 pwdata[31:`CSS_SEL_W] == 28'h0 &&
                 pwdata[`CSS_SEL_W-1:0] <= `CSS_SEL_MAX) begin
      // keep old value on bad data
      serial_link_source_select_reg <= pwdata[`CSS_SEL_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fieldbus_source_override_reg <= `CSS_OVR_RST;
    end else if (wr_en && hit(paddr, `CSS_OVR_OFS) &&
                 pwdata[31:`CSS_OVR_W] == 30'h0) begin
      // keep old value on bad data
      fieldbus_source_override_reg <= pwdata[`CSS_OVR_W-1:0];
    end
  end

  // Local source configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      local_cfg_reg <= `CSS_LOC_RST;
    end else if (wr_en && hit(paddr, `CSS_LOC_OFS)) begin
      local_cfg_reg <= pwdata[1:0];
    end
  end

  // sticky reject flag, set beats read clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reject_reg <= 1'b0;
    end else if (wr_en && hit(paddr, `CSS_SEL_OFS) &&
                 (pwdata[31:`CSS_SEL_W] != 28'h0 ||
                  pwdata[`CSS_SEL_W-1:0] > `CSS_SEL_MAX)) begin
      reject_reg <= 1'b1;
    end else if (wr_en && hit(paddr, `CSS_OVR_OFS) &&
                 pwdata[31:`CSS_OVR_W] != 30'h0) begin
      reject_reg <= 1'b1;
    end else if (rd_en && hit(paddr, `CSS_STAT_OFS)) begin
      reject_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // APB answer: no wait state, pready registered

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && !penable;
    end
  end

  // Unmapped addresses answer with an error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= psel && !penable && !mapped;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= 32'h0;
      if (hit(paddr, `CSS_SEL_OFS)) begin
        prdata[`CSS_SEL_W-1:0] <= serial_link_source_select_reg;
      end
      if (hit(paddr, `CSS_OVR_OFS)) begin
        prdata[`CSS_OVR_W-1:0] <= fieldbus_source_override_reg;
      end
      if (hit(paddr, `CSS_LOC_OFS)) begin
        prdata[1:0] <= local_cfg_reg;
      end
      if (hit(paddr, `CSS_STAT_OFS)) begin
        prdata[`CSS_ST_FRQ_LSB +: 2] <= frq_src;
        prdata[`CSS_ST_RUN_LSB +: 2] <= run_src;
        prdata[`CSS_ST_EFF_BIT] <= effective;
        prdata[`CSS_ST_REJ_BIT] <= reject_reg;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Source selection

  css_decode u_decode (
    .sel(serial_link_source_select_reg),
    .ovr(fieldbus_source_override_reg),
    .effective(effective),
    .frq_src(frq_src),
    .run_src(run_src)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      freq_cmd <= '0;
    end else begin
      unique case (frq_src)
        CSS_SRC_LOCAL: begin
          if (multistep_active) begin
            freq_cmd <= multistep_freq;
          end else if (local_cfg_reg[0]) begin
            freq_cmd <= local_frequency_setting_alt;
          end else begin
            freq_cmd <= local_frequency_setting;
          end
        end
        CSS_SRC_STD: freq_cmd <= std_freq;
        CSS_SRC_EXT: freq_cmd <= ext_freq;
        CSS_SRC_FBUS: freq_cmd <= fbus_freq;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_cmd <= 2'h0;
    end else begin
      unique case (run_src)
        CSS_SRC_LOCAL: run_cmd <= local_cfg_reg[1] ? keypad_run : terminal_run;
        CSS_SRC_STD: run_cmd <= std_run;
        CSS_SRC_EXT: run_cmd <= ext_run;
        CSS_SRC_FBUS: run_cmd <= fbus_run;
      endcase
    end
  end

  // Source indication outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      freq_src_out <= 2'h0;
      run_src_out <= 2'h0;
    end else begin
      freq_src_out <= frq_src;
      run_src_out <= run_src;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  AST_SEL_RANGE: assert property (@(posedge pclk)
    disable iff (!presetn) serial_link_source_select_reg <= `CSS_SEL_MAX)
    else $error("serial selector out of range");

  AST_BAD_KEEP: assert property (@(posedge pclk)
    disable iff (!presetn) (wr_en && hit(paddr, `CSS_SEL_OFS) &&
    pwdata > 32'h8) |=> $stable(serial_link_source_select_reg))
    else $error("bad selector write changed value");

  AST_VOID_LOCAL: assert property (@(posedge pclk)
    disable iff (!presetn) !effective |=>
    freq_src_out == 2'h0 && run_src_out == 2'h0)
    else $error("ineffective settings not local");

  AST_OPEN_TERM: assert property (@(posedge pclk)
    disable iff (!presetn) (link_enable_assigned && link_enable_input_n)
    |-> frq_src == CSS_SRC_LOCAL)
    else $error("open terminal did not void settings");

  AST_FBUS_FRQ: assert property (@(posedge pclk)
    disable iff (!presetn) (effective && fieldbus_source_override_reg[0])
    |=> freq_src_out == 2'h3)
    else $error("frequency not forced to field bus");

  AST_FBUS_RUN: assert property (@(posedge pclk)
    disable iff (!presetn) (effective && fieldbus_source_override_reg ==
    2'h2) |=> run_src_out == 2'h3 && freq_src_out != 2'h3)
    else $error("run override wrong");

  AST_FRQ_STD: assert property (@(posedge pclk)
    disable iff (!presetn) (effective && fieldbus_source_override_reg ==
    2'h0 && serial_link_source_select_reg == 4'h7) |->
    frq_src == CSS_SRC_STD && run_src == CSS_SRC_EXT)
    else $error("selector 7 decode wrong");

  AST_RUN_STD: assert property (@(posedge pclk)
    disable iff (!presetn) (effective && fieldbus_source_override_reg ==
    2'h0 && serial_link_source_select_reg == 4'h5) |->
    run_src == CSS_SRC_STD && frq_src == CSS_SRC_EXT)
    else $error("selector 5 decode wrong");

  AST_RUN_FOLLOW: assert property (@(posedge pclk)
    disable iff (!presetn) run_src == CSS_SRC_STD |=>
    run_cmd == $past(std_run))
    else $error("run command not from standard link");

  AST_APB_WAIT: assert property (@(posedge pclk)
    disable iff (!presetn) (psel && !penable) |=> pready ##1 !pready)
    else $error("apb answer timing wrong");
endmodule

/* css_consts.svh */
// Constants for the command source selector: offsets, fields, resets.
// Assumes inclusion by the selector modules and the bench.
`ifndef CSS_CONSTS_SVH
`define CSS_CONSTS_SVH
// Register byte offsets
`define CSS_SEL_OFS 12'h000
`define CSS_OVR_OFS 12'h004
`define CSS_LOC_OFS 12'h008
`define CSS_STAT_OFS 12'h00c
// Field widths and limits
`define CSS_SEL_W 4
`define CSS_OVR_W 2
`define CSS_SEL_MAX 4'h8
// Reset values
`define CSS_SEL_RST 4'h0
`define CSS_OVR_RST 2'h0
`define CSS_LOC_RST 2'h0
// Status field positions
`define CSS_ST_FRQ_LSB 0
`define CSS_ST_RUN_LSB 4
`define CSS_ST_EFF_BIT 8
`define CSS_ST_REJ_BIT 9
`endif

/* css_pkg.sv */
// Types for the command source selector.
// Assumes css_consts.svh sits in the same folder.
package css_pkg;
  // Where a command is taken from
  typedef enum logic [1:0] {
    CSS_SRC_LOCAL = 2'h0,
    CSS_SRC_STD = 2'h1,
    CSS_SRC_EXT = 2'h2,
    CSS_SRC_FBUS = 2'h3
  } css_src_t;
endpackage

/* css_decode.sv */
// Combinational decoder from the two selectors to the two sources.
// Assumes the parent registers sel, ovr and the outputs; effective arrives unregistered.
`timescale 1ns/1ps
`include "css_consts.svh"
module css_decode
  import css_pkg::*;
(
  // Settings
  input wire logic [`CSS_SEL_W-1:0] sel,
  input wire logic [`CSS_OVR_W-1:0] ovr,
  input wire logic effective,
  // Chosen sources
  output css_src_t frq_src,
  output css_src_t run_src
);
  // Frequency and run source per selector value
  always_comb begin
    frq_src = CSS_SRC_LOCAL;
    run_src = CSS_SRC_LOCAL;
    if (effective) begin
      unique case (sel)
        4'h1, 4'h3, 4'h7: frq_src = CSS_SRC_STD;
        4'h4, 4'h5, 4'h8: frq_src = CSS_SRC_EXT;
        default: frq_src = CSS_SRC_LOCAL;
      endcase
      unique case (sel)
        4'h2, 4'h3, 4'h5: run_src = CSS_SRC_STD;
        4'h6, 4'h7, 4'h8: run_src = CSS_SRC_EXT;
        default: run_src = CSS_SRC_LOCAL;
      endcase
      if (ovr[0]) begin
        frq_src = CSS_SRC_FBUS;
      end
      if (ovr[1]) begin
        run_src = CSS_SRC_FBUS;
      end
    end
  end
endmodule

/* css_remote_model.sv */
// Remote computer model driving the three link command sources.
// Assumes one pclk domain; the bench strobes upd to load new commands.
`timescale 1ns/1ps
module css_remote_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Load control
  input wire logic upd,
  input wire logic [15:0] base,
  // Link commands
  output logic [15:0] std_freq,
  output logic [1:0] std_run,
  output logic [15:0] ext_freq,
  output logic [1:0] ext_run,
  output logic [15:0] fbus_freq,
  output logic [1:0] fbus_run
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {std_freq, std_run, ext_freq, ext_run} <= 36'h0;
      {fbus_freq, fbus_run} <= 18'h0;
    end else if (upd) begin
      std_freq <= base ^ 16'h1111;
      std_run <= base[1:0];
      ext_freq <= base ^ 16'h2222;
      ext_run <= base[3:2];
      fbus_freq <= base ^ 16'h4444;
      fbus_run <= base[5:4];
    end
  end
endmodule

/* tb.sv */
// Self-checking bench for the command source selector.
// Assumes the selector design files and remote model compile first.
`timescale 1ns/1ps
`include "css_consts.svh"
module tb;
  import css_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, lea = 1'b0, len = 1'b1;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [15:0] lf = 16'h0, lfa = 16'h0, msf = 16'h0, base = 16'h0;
  logic msa = 1'b0, upd = 1'b0, err, eff;
  logic [1:0] kr = 2'h0, tr = 2'h0, cfg, fs, rs;
  logic [15:0] std_freq, ext_freq, fbus_freq, freq_cmd;
  logic [1:0] std_run, ext_run, fbus_run, run_cmd, freq_src_out, run_src_out;
  int failures = 0, num_checks = 0, cyc = 0, seed = 32'h0f62, s, o;

  ////////////////////////////////////////////////////////////////////////
  // Design and far side
  css_selector #(.FREQ_W(16)) dut (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .link_enable_assigned(lea), .link_enable_input_n(len),
    .local_frequency_setting(lf), .local_frequency_setting_alt(lfa),
    .multistep_freq(msf), .multistep_active(msa), .keypad_run(kr),
    .terminal_run(tr), .std_freq, .std_run, .ext_freq, .ext_run,
    .fbus_freq, .fbus_run, .freq_cmd, .run_cmd, .freq_src_out,
    .run_src_out);
  css_remote_model remote (.pclk, .presetn, .upd, .base, .std_freq,
    .std_run, .ext_freq, .ext_run, .fbus_freq, .fbus_run);

  // Clock and hang guard
  always #5 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      failures++;
      finish_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Compare and bus tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic finish_test();
    $display("Checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Expected sources and commands
  function automatic logic [1:0] efs(int s, int o, logic e);
    if (!e) return 2'h0;
    if (o[0]) return 2'h3;
    case (s)
      0, 2, 6: return 2'h0;
      1, 3, 7: return 2'h1;
      default: return 2'h2;
    endcase
  endfunction

  function automatic logic [1:0] ers(int s, int o, logic e);
    if (!e) return 2'h0;
    if (o[1]) return 2'h3;
    case (s)
      0, 1, 4: return 2'h0;
      2, 3, 5: return 2'h1;
      default: return 2'h2;
    endcase
  endfunction

  function automatic logic [15:0] efv(logic [1:0] src);
    case (src)
      2'h0: return msa ? msf : (cfg[0] ? lfa : lf);
      2'h1: return base ^ 16'h1111;
      2'h2: return base ^ 16'h2222;
      default: return base ^ 16'h4444;
    endcase
  endfunction

  function automatic logic [1:0] erv(logic [1:0] src);
    case (src)
      2'h0: return cfg[1] ? kr : tr;
      2'h1: return base[1:0];
      2'h2: return base[3:2];
      default: return base[5:4];
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (2) @(posedge pclk);
    chk(32'(freq_cmd), 32'h0);
    chk(32'(run_cmd), 32'h0);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `CSS_SEL_OFS, 32'h0);
    chk(rd, 32'h0);
    chk(32'(err), 32'h0);
    apb(1'b0, `CSS_OVR_OFS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, `CSS_STAT_OFS, 32'h0);
    chk(rd, 32'h100);
    // Every selector and override code
    for (s = 0; s < 9; s++) begin
      for (o = 0; o < 4; o++) begin
        cfg = 2'($random(seed));
        lea <= 1'($random(seed));
        len <= 1'($random(seed));
        {lf, lfa} <= 32'($random(seed));
        {msf, base} <= 32'($random(seed));
        {msa, kr, tr} <= 5'($random(seed));
        upd <= 1'b1;
        apb(1'b1, `CSS_SEL_OFS, 32'(s));
        upd <= 1'b0;
        apb(1'b1, `CSS_OVR_OFS, 32'(o));
        apb(1'b1, `CSS_LOC_OFS, 32'(cfg));
        repeat (2) @(posedge pclk);
        eff = !lea || !len;
        fs = efs(s, o, eff);
        rs = ers(s, o, eff);
        chk(32'(freq_src_out), 32'(fs));
        chk(32'(run_src_out), 32'(rs));
        chk(32'(freq_cmd), 32'(efv(fs)));
        chk(32'(run_cmd), 32'(erv(rs)));
        apb(1'b0, `CSS_STAT_OFS, 32'h0);
        chk(rd, {22'h0, 1'b0, eff, 2'h0, rs, 2'h0, fs});
      end
    end
    // Rejected writes keep the old selection
    apb(1'b1, `CSS_SEL_OFS, 32'h9);
    apb(1'b0, `CSS_SEL_OFS, 32'h0);
    chk(rd, 32'h8);
    apb(1'b0, `CSS_STAT_OFS, 32'h0);
    chk(32'(rd[9]), 32'h1);
    apb(1'b0, `CSS_STAT_OFS, 32'h0);
    chk(32'(rd[9]), 32'h0);
    apb(1'b1, `CSS_SEL_OFS, 32'h12);
    apb(1'b0, `CSS_SEL_OFS, 32'h0);
    chk(rd, 32'h8);
    apb(1'b1, `CSS_OVR_OFS, 32'h4);
    apb(1'b0, `CSS_OVR_OFS, 32'h0);
    chk(rd, 32'h3);
    apb(1'b0, `CSS_STAT_OFS, 32'h0);
    chk(32'(rd[9]), 32'h1);
    // Local configuration reads back
    apb(1'b0, `CSS_LOC_OFS, 32'h0);
    chk(rd, 32'(cfg));
    chk(32'(err), 32'h0);
    // Unmapped address answers with an error
    apb(1'b0, 12'h010, 32'h0);
    chk(32'(err), 32'h1);
    finish_test();
  end
endmodule
